// ==== rpds_pkg.sv ====
// Purpose: Shared constants for the regulator power-down sequencer
// Assumes: 50 MHz clock, seven rails, 3-bit order fields
// Notes: Rail index order is buck1, buck2, buck3, linreg1, linreg2, linreg3, memref
package rpds_pkg;

  localparam int RPDS_RAILS = 7;
  localparam int RPDS_OW = 3;
  localparam int RPDS_FLAT_W = RPDS_RAILS * RPDS_OW;

  // Register offsets, one byte register per rail
  localparam logic [7:0] RPDS_OFFS_BUCK1 = 8'h60;
  localparam logic [7:0] RPDS_OFFS_BUCK2 = 8'h61;
  localparam logic [7:0] RPDS_OFFS_LINREG1 = 8'h62;
  localparam logic [7:0] RPDS_OFFS_LINREG2 = 8'h63;
  localparam logic [7:0] RPDS_OFFS_LINREG3 = 8'h64;
  localparam logic [7:0] RPDS_OFFS_BUCK3 = 8'h65;
  localparam logic [7:0] RPDS_OFFS_MEMREF = 8'h66;

  // Offsets indexed by rail number
  localparam logic [7:0] RPDS_OFFS [RPDS_RAILS] = '{
    RPDS_OFFS_BUCK1, RPDS_OFFS_BUCK2, RPDS_OFFS_BUCK3,
    RPDS_OFFS_LINREG1, RPDS_OFFS_LINREG2, RPDS_OFFS_LINREG3, RPDS_OFFS_MEMREF};

  // Field layout
  localparam int RPDS_ORD_LSB = 0;
  localparam int RPDS_ORD_MSB = 2;
  localparam logic [4:0] RPDS_UNUSED_VAL = 5'h0_0;
  localparam logic [7:0] RPDS_UNMAPPED_VAL = 8'h00;

  // Reset values, plus the all-off enable pattern
  localparam logic [2:0] RPDS_ORD_RST = 3'h0;
  localparam logic [6:0] RPDS_EN_RST = 7'h7F;
  localparam logic [6:0] RPDS_EN_OFF = 7'h00;

  // Step timing
  localparam int RPDS_CLK_MHZ = 50;
  localparam int RPDS_STEP_US = 2;
  localparam int RPDS_STEP_CYC = RPDS_STEP_US * RPDS_CLK_MHZ;
  localparam logic [7:0] RPDS_STEP_CNT = 8'(RPDS_STEP_CYC - 1);

  typedef enum logic [1:0] {
    RPDS_IDLE = 2'b00,
    RPDS_STEP = 2'b01,
    RPDS_WAIT = 2'b10,
    RPDS_DONE = 2'b11
  } rpds_state_t;

endpackage : rpds_pkg

// ==== rpds_order_match.sv ====
// Purpose: Per-rail position compare and highest-position search
// Assumes: Flat order vector, rail i at bits 3i+2..3i
// Notes: Pure combinational, shared by the sequencer
`timescale 1ns/1ps
module rpds_order_match
  import rpds_pkg::*;
(
  input wire logic [RPDS_FLAT_W-1:0] orders,
  input wire logic [RPDS_OW-1:0] position,
  output logic [RPDS_RAILS-1:0] match,
  output logic [RPDS_OW-1:0] max_pos,
  output logic all_zero
);

  logic [RPDS_OW-1:0] max_v [RPDS_RAILS+1];

  assign max_v[0] = RPDS_ORD_RST;

  // Per-rail compare plus running maximum
  genvar i;
  generate
    for (i = 0; i < RPDS_RAILS; i++) begin : g_rail
      wire [RPDS_OW-1:0] ord = orders[i*RPDS_OW +: RPDS_OW];
      assign match[i] = (ord == position);
      assign max_v[i+1] = (ord > max_v[i]) ? ord : max_v[i];
    end
  endgenerate

  assign max_pos = max_v[RPDS_RAILS];
  assign all_zero = ~|orders;

endmodule : rpds_order_match

// ==== rpds_sequencer.sv ====
// Purpose: Power-down order registers and rail shutdown sequencer
// Assumes: All control inputs come from logic on the same clock
// Notes: Order registers load from the selected startup source after reset
`timescale 1ns/1ps
module rpds_sequencer
  import rpds_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic system_on,
  input wire logic [RPDS_FLAT_W-1:0] fuse_startup_order,
  input wire logic trial_programming_mode,
  input wire logic [RPDS_FLAT_W-1:0] trial_startup_order,
  output logic [RPDS_FLAT_W-1:0] startup_order,
  input wire logic power_down_start,
  input wire logic power_up_restore,
  output logic [RPDS_RAILS-1:0] rail_enable,
  output logic power_down_busy
);

  logic [RPDS_OW-1:0] order_r [RPDS_RAILS];
  wire [RPDS_FLAT_W-1:0] order_flat;
  logic load_pend_r;
  logic [RPDS_FLAT_W-1:0] startup_r;
  logic [7:0] rdata_r;
  logic [RPDS_RAILS-1:0] en_r;
  logic [RPDS_RAILS-1:0] en_nxt;
  logic [RPDS_OW-1:0] pos_r;
  logic [RPDS_OW-1:0] pos_nxt;
  logic [7:0] dly_r;
  logic [7:0] dly_nxt;
  logic busy_r;
  rpds_state_t state_r;
  rpds_state_t state_nxt;

  wire [RPDS_RAILS-1:0] addr_hit;
  wire [RPDS_RAILS-1:0] step_match;
  wire [RPDS_OW-1:0] max_pos;
  wire all_zero;
  wire [RPDS_FLAT_W-1:0] startup_src;
  wire wr_ok;
  wire [7:0] rd_sel;
  wire start_seq;

  // startup source is fuses or trial only
  assign startup_src = trial_programming_mode ? trial_startup_order : fuse_startup_order;

  // writes only in system-on, idle, after load
  assign wr_ok = reg_write && system_on && !load_pend_r && (state_r == RPDS_IDLE);
  assign start_seq = power_down_start && (state_r == RPDS_IDLE) && !load_pend_r;

  // Address decode and flattened view of the order fields
  genvar i;
  generate
    for (i = 0; i < RPDS_RAILS; i++) begin : g_reg
      assign addr_hit[i] = (reg_addr == RPDS_OFFS[i]);
      assign order_flat[i*RPDS_OW +: RPDS_OW] = order_r[i];
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          order_r[i] <= RPDS_ORD_RST;
        end else if (load_pend_r) begin
          order_r[i] <= startup_src[i*RPDS_OW +: RPDS_OW];
        end else if (wr_ok && addr_hit[i]) begin
          order_r[i] <= reg_wdata[RPDS_ORD_MSB:RPDS_ORD_LSB];
        end
      end
    end
  endgenerate

  // Read mux, unused bits and unmapped addresses read zero
  assign rd_sel = (addr_hit[0]) ? {RPDS_UNUSED_VAL, order_r[0]} :
                  (addr_hit[1]) ? {RPDS_UNUSED_VAL, order_r[1]} :
                  (addr_hit[2]) ? {RPDS_UNUSED_VAL, order_r[2]} :
                  (addr_hit[3]) ? {RPDS_UNUSED_VAL, order_r[3]} :
                  (addr_hit[4]) ? {RPDS_UNUSED_VAL, order_r[4]} :
                  (addr_hit[5]) ? {RPDS_UNUSED_VAL, order_r[5]} :
                  (addr_hit[6]) ? {RPDS_UNUSED_VAL, order_r[6]} : RPDS_UNMAPPED_VAL;

  rpds_order_match u_match (
    .orders(order_flat),
    .position(pos_r),
    .match(step_match),
    .max_pos(max_pos),
    .all_zero(all_zero)
  );

  // Sequencer next state; one step per position from the highest in use down to 0, empty ones still wait
  always_comb begin
    state_nxt = state_r;
    en_nxt = en_r;
    pos_nxt = pos_r;
    dly_nxt = dly_r;
    case (state_r)
      RPDS_IDLE: begin
        if (start_seq) begin
          if (all_zero) begin
            en_nxt = RPDS_EN_OFF;
            state_nxt = RPDS_DONE;
          end else begin
            pos_nxt = max_pos;
            state_nxt = RPDS_STEP;
          end
        end
      end
      RPDS_STEP: begin
        en_nxt = en_r & ~step_match;
        if (pos_r == RPDS_ORD_RST) begin
          state_nxt = RPDS_DONE;
        end else begin
          dly_nxt = RPDS_STEP_CNT;
          state_nxt = RPDS_WAIT;
        end
      end
      RPDS_WAIT: begin
        // fixed gap, then next lower position
        if (dly_r == 8'h00) begin
          pos_nxt = pos_r - 3'h1;
          state_nxt = RPDS_STEP;
        end else begin
          dly_nxt = dly_r - 8'h01;
        end
      end
      RPDS_DONE: begin
        if (power_up_restore) begin
          en_nxt = RPDS_EN_RST;
          state_nxt = RPDS_IDLE;
        end
      end
      default: begin
        state_nxt = RPDS_IDLE;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r <= RPDS_IDLE;
      en_r <= RPDS_EN_RST;
      pos_r <= RPDS_ORD_RST;
      dly_r <= 8'h00;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      en_r <= en_nxt;
      pos_r <= pos_nxt;
      dly_r <= dly_nxt;
      busy_r <= (state_nxt != RPDS_IDLE);
    end
  end

  // Load flag, read data and startup copy; load waits for reset release
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      load_pend_r <= 1'b1;
      startup_r <= '0;
      rdata_r <= RPDS_UNMAPPED_VAL;
    end else begin
      load_pend_r <= 1'b0;
      startup_r <= startup_src;
      rdata_r <= reg_read ? rd_sel : rdata_r;
    end
  end

  assign reg_rdata = rdata_r;
  assign startup_order = startup_r;
  assign rail_enable = en_r;
  assign power_down_busy = busy_r;

  // Assertions
  // Release edge still samples reset high, so the load is checked one edge later
  a_load_copy: assert property (@(posedge clock) disable iff (reset)
    (load_pend_r && !reset) |=> order_flat == $past(startup_src))
    else $error("order not loaded from startup order");

  a_unused_zero: assert property (@(posedge clock) disable iff (reset)
    $past(reg_read) |-> rdata_r[7:3] == RPDS_UNUSED_VAL)
    else $error("unused bits read nonzero");

  a_write_gated: assert property (@(posedge clock) disable iff (reset)
    (!load_pend_r && (!system_on || state_r != RPDS_IDLE)) |=> $stable(order_flat))
    else $error("order changed outside system-on");

  a_write_apply: assert property (@(posedge clock) disable iff (reset)
    (wr_ok && addr_hit[3]) |=> order_r[3] == $past(reg_wdata[2:0]))
    else $error("accepted write not stored");

  a_bypass_all: assert property (@(posedge clock) disable iff (reset)
    (start_seq && all_zero) |=> (rail_enable == RPDS_EN_OFF) && (state_r == RPDS_DONE))
    else $error("all-zero bypass failed");

  a_step_down: assert property (@(posedge clock) disable iff (reset)
    (state_r == RPDS_WAIT && dly_r == 8'h00) |=> state_r == RPDS_STEP && pos_r == $past(pos_r) - 3'h1)
    else $error("step did not move to next lower position");

  a_step_gap: assert property (@(posedge clock) disable iff (reset)
    (state_r == RPDS_STEP && pos_r != RPDS_ORD_RST) |=> (state_r == RPDS_WAIT)[*8])
    else $error("step gap too short");

  a_step_group: assert property (@(posedge clock) disable iff (reset)
    state_r == RPDS_STEP |=> (rail_enable & $past(step_match)) == RPDS_EN_OFF)
    else $error("matching rails not disabled together");

  a_startup_src: assert property (@(posedge clock) disable iff (reset)
    !reset |=> startup_order == $past(trial_programming_mode ? trial_startup_order :
      fuse_startup_order))
    else $error("startup order not from fuse or trial source");

endmodule : rpds_sequencer

// ==== rpds_rail_model.sv ====
// Purpose: Far-side rail loads, reporting rails that lose enable
// Assumes: Rails drop on the enable edge, no analog ramp modelled
// Notes: Re-enables are not reported, only switch-offs
`timescale 1ns/1ps
module rpds_rail_model
  import rpds_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [RPDS_RAILS-1:0] rail_enable,
  output logic [RPDS_RAILS-1:0] went_off
);
  logic [RPDS_RAILS-1:0] seen_r;
  // Enables as the loads saw them at the last edge
  always_ff @(posedge clock or posedge reset) begin
    if (reset) seen_r <= RPDS_EN_RST;
    else seen_r <= rail_enable;
  end
  // Rails dropped since that edge
  assign went_off = seen_r & ~rail_enable;
endmodule : rpds_rail_model

// ==== rpds_sequencer_test.sv ====
// Purpose: Self-checking bench for the power-down sequencer
// Assumes: 50 MHz clock, reset held five cycles
// Notes: Expected results carry their cycle, so late steps fail too
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module rpds_sequencer_test
  import rpds_pkg::*;
;
  logic clock, reset, reg_write, reg_read, system_on, trial_programming_mode;
  logic power_down_start, power_up_restore, power_down_busy, rd_d;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [RPDS_FLAT_W-1:0] fuse_startup_order, trial_startup_order, startup_order;
  logic [RPDS_RAILS-1:0] rail_enable, went_off;
  logic [2:0] ord [RPDS_RAILS];
  logic [31:0] exp_q [$];
  logic [31:0] e;
  int cyc, mismatches, tests_run;

  rpds_sequencer uut (.clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .system_on(system_on), .fuse_startup_order(fuse_startup_order),
    .trial_programming_mode(trial_programming_mode),
    .trial_startup_order(trial_startup_order), .startup_order(startup_order),
    .power_down_start(power_down_start), .power_up_restore(power_up_restore),
    .rail_enable(rail_enable), .power_down_busy(power_down_busy));
  rpds_rail_model loads (.clock(clock), .reset(reset), .rail_enable(rail_enable),
    .went_off(went_off));

  always #10 clock = ~clock;
  // Cycle count by NBA so stimulus reads the pre-edge value
  always @(posedge clock) begin
    cyc <= cyc + 1;
    rd_d <= reg_read;
    if (cyc > 20000) begin
      mismatches++;
      finish_test();
    end
  end
  // Monitor at the falling edge, where outputs are settled
  always @(negedge clock) begin
    if (rd_d) begin
      e = exp_q.pop_front();
      `CHK({reg_rdata, 24'(cyc)}, e)
    end
    if (|went_off) begin
      e = exp_q.pop_front();
      `CHK({1'b0, went_off, 24'(cyc)}, e)
    end
  end

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  // Read data lands at the same edge that takes the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    exp_q.push_back({x, 24'(cyc + 2)});
    @(posedge clock);
    reg_read <= 1'b0;
  endtask : rd

  task automatic rd_all();
    for (int i = 0; i < RPDS_RAILS; i++) rd(RPDS_OFFS[i], {5'h0_0, ord[i]});
  endtask : rd_all

  // Both sources random so a wrong source choice shows
  task automatic do_reset(input logic tm);
    logic [20:0] f, t;
    f = 21'($urandom);
    t = 21'($urandom);
    @(posedge clock);
    reset <= 1'b1;
    trial_programming_mode <= tm;
    fuse_startup_order <= f;
    trial_startup_order <= t;
    for (int i = 0; i < RPDS_RAILS; i++) ord[i] = tm ? t[3*i +: 3] : f[3*i +: 3];
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    `CHK(startup_order, tm ? t : f)
  endtask : do_reset

  task automatic pd();
    int mx, n;
    logic [6:0] m;
    mx = 0;
    foreach (ord[i]) if (ord[i] > mx) mx = ord[i];
    @(posedge clock);
    power_down_start <= 1'b1;
    @(posedge clock);
    power_down_start <= 1'b0;
    n = cyc;
    for (int p = 7; p >= 0; p--) begin
      m = '0;
      foreach (ord[i]) if (ord[i] == p) m[i] = 1'b1;
      if (|m) exp_q.push_back({1'b0, m, 24'(mx == 0 ? n + 1 : n + 2 + (mx - p) * 101)});
    end
    repeat (mx * 101 + 6) @(posedge clock);
    `CHK({power_down_busy, rail_enable}, 8'h80)
    // Write while shut down must be dropped
    wr(RPDS_OFFS[0], {5'h0_0, ~ord[0]});
    power_up_restore <= 1'b1;
    @(posedge clock);
    power_up_restore <= 1'b0;
    @(posedge clock);
    `CHK({power_down_busy, rail_enable}, {1'b0, RPDS_EN_RST})
    rd(RPDS_OFFS[0], {5'h0_0, ord[0]});
  endtask : pd

  initial begin
    logic [7:0] d;
    logic [20:0] keep;
    {clock, reset, reg_write, reg_read, system_on, trial_programming_mode} = '0;
    {power_down_start, power_up_restore, rd_d, cyc, mismatches, tests_run} = '0;
    {reg_addr, reg_wdata, fuse_startup_order, trial_startup_order} = '0;
    void'($urandom(32'h1e6f));
    for (int k = 0; k < 2; k++) begin
      do_reset(k[0]);
      keep = k[0] ? trial_startup_order : fuse_startup_order;
      rd_all();
      wr(RPDS_OFFS[4], 8'hff);
      rd_all();
      system_on <= 1'b1;
      // Random, all-zero, random again
      for (int it = 0; it < 3; it++) begin
        for (int i = 0; i < RPDS_RAILS; i++) begin
          d = (it == 1) ? 8'($urandom) & 8'hf8 : 8'($urandom);
          ord[i] = d[2:0];
          wr(RPDS_OFFS[i], d);
        end
        wr(8'h70, 8'h07);
        rd(8'h70, RPDS_UNMAPPED_VAL);
        rd_all();
        pd();
        `CHK(startup_order, keep)
      end
      system_on <= 1'b0;
    end
    repeat (4) @(posedge clock);
    `CHK(exp_q.size(), 0)
    finish_test();
  end
endmodule : rpds_sequencer_test
